// File: src/rcp_pkg.sv
// Package for the slow counter and periodic timer block
package rcp_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTL_A = 6'h00;
	localparam logic [5:0] IDX_SYNC_STATUS = 6'h01;
	localparam logic [5:0] IDX_IRQ_EN = 6'h02;
	localparam logic [5:0] IDX_IRQ_FLAGS = 6'h03;
	localparam logic [5:0] IDX_WIDE_BUF = 6'h04;
	localparam logic [5:0] IDX_DEBUG = 6'h05;
	localparam logic [5:0] IDX_CLK_SEL = 6'h07;
	localparam logic [5:0] IDX_COUNT_L = 6'h08;
	localparam logic [5:0] IDX_COUNT_H = 6'h09;
	localparam logic [5:0] IDX_TOP_L = 6'h0a;
	localparam logic [5:0] IDX_TOP_H = 6'h0b;
	localparam logic [5:0] IDX_MATCH_L = 6'h0c;
	localparam logic [5:0] IDX_MATCH_H = 6'h0d;
	localparam logic [5:0] IDX_PRD_CTL = 6'h10;
	localparam logic [5:0] IDX_PRD_STATUS = 6'h11;
	localparam logic [5:0] IDX_PRD_IRQ_EN = 6'h12;
	localparam logic [5:0] IDX_PRD_FLAGS = 6'h13;
	localparam logic [5:0] IDX_PRD_DEBUG = 6'h15;
	// Field positions
	localparam int RUN_IN_STANDBY_BIT = 7;
	localparam int PRESC_LSB = 3;
	localparam int COUNTER_ENABLE_BIT = 0;
	localparam int PERIODIC_ENABLE_BIT = 0;
	localparam int PRD_FIELD_LSB = 3;
	localparam int MATCH_SRC_BIT = 1;
	localparam int WRAP_SRC_BIT = 0;
	localparam logic [7:0] CTL_A_WMASK = 8'hf9;
	localparam logic [7:0] PRD_CTL_WMASK = 8'h79;
	// Reset values
	localparam logic [7:0] CTL_A_RST = 8'h00;
	localparam logic [15:0] TOP_RST = 16'hffff;
	// Slow ticks from write to effect
	localparam logic [1:0] SYNC_TICKS = 2'h2;
	// Periodic events: output 0 every 2**13 ticks, each next halves
	localparam logic [3:0] PRD_EVT_LOG2_MAX = 4'hd;
	localparam int PRD_EVT_N = 8;
	// Interrupt vector offsets
	localparam logic [7:0] VEC_COUNTER = 8'h00;
	localparam logic [7:0] VEC_PERIODIC = 8'h02;

	typedef enum logic [1:0] {SLEEP_ACTIVE, SLEEP_IDLE, SLEEP_STANDBY, SLEEP_POWER_DOWN} rcp_sleep_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} rcp_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rcp_wb_rsp_t;

	typedef struct packed {
		logic wrap_source;
		logic compare_match_source;
		logic [PRD_EVT_N-1:0] periodic;
	} rcp_evt_t;

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic src_prev;
		logic ack;
		logic [7:0] rdat;
		logic [7:0] ctl_a;
		logic [7:0] ctl_a_act;
		logic [1:0] irq_en;
		logic [1:0] flags;
		logic [7:0] wide_buf;
		logic run_halted;
		logic [1:0] clk_src_sel;
		logic [15:0] count;
		logic [15:0] count_stage;
		logic [15:0] top;
		logic [15:0] top_act;
		logic [15:0] match;
		logic [15:0] match_act;
		logic [7:0] prd_ctl;
		logic [7:0] prd_ctl_act;
		logic prd_irq_en;
		logic prd_flag;
		logic prd_run_halted;
		logic [1:0] busy_ctl;
		logic [1:0] busy_count;
		logic [1:0] busy_top;
		logic [1:0] busy_match;
		logic [1:0] busy_prd;
		logic [14:0] presc;
		logic [14:0] prd_count;
		rcp_evt_t evt;
	} rcp_state_t;
endpackage

// File: src/rcp_top.sv
// Slow counter with period, compare and periodic interval timer
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps

module rcp_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire rcp_pkg::rcp_wb_req_t wb_req,
	output rcp_pkg::rcp_wb_rsp_t wb_rsp,
	input wire logic internal_low_power_osc,
	input wire logic internal_low_power_osc_1k,
	input wire logic watch_crystal_osc,
	input wire logic external_slow_clock_pin,
	input wire rcp_pkg::rcp_sleep_t sleep_mode,
	input wire logic debug_halt,
	output logic irq_counter,
	output logic irq_periodic,
	output rcp_pkg::rcp_evt_t events
);
	import rcp_pkg::*;

	rcp_state_t s_reg;
	rcp_state_t s_next;

	// True when the low n bits of v are all ones
	function automatic logic low_ones(input logic [14:0] v, input logic [3:0] n);
		logic [15:0] m;
		m = (16'h0001 << n) - 16'h0001;
		return ({1'b0, v} & m) == m;
	endfunction

	// A staged write lands on the tick that ends its countdown
	function automatic logic lands(input logic [1:0] b, input logic tick);
		return tick && (b == 2'h1);
	endfunction

	function automatic logic [1:0] step(input logic [1:0] b, input logic tick);
		return (tick && b != 2'h0) ? b - 2'h1 : b;
	endfunction

	logic req;
	logic wr;
	logic [5:0] idx;
	logic [7:0] wd;
	logic src_lvl;
	logic tick;
	logic run_c;
	logic run_p;
	logic standby_stop;
	logic ctick;
	logic ptick;
	logic [3:0] prd_code;
	logic [1:0] set_flags;

	always_comb begin
		s_next = s_reg;
		req = wb_req.cyc & wb_req.stb & ~s_reg.ack;
		wr = req & wb_req.we & wb_req.sel[0];
		idx = wb_req.adr[7:2];
		wd = wb_req.dat[7:0];

		// Pins pass two flops; only the second stage is looked at
		s_next.sync1 = {external_slow_clock_pin, watch_crystal_osc,
			internal_low_power_osc_1k, internal_low_power_osc};
		s_next.sync2 = s_reg.sync1;
		// Vector order equals the select codes
		src_lvl = s_reg.sync2[s_reg.clk_src_sel];
		// Single rising-edge tick shared by both timers
		tick = src_lvl & ~s_reg.src_prev;
		s_next.src_prev = src_lvl;

		// Bus side
		s_next.ack = req;
		s_next.rdat = s_reg.rdat;
		if (req && !wb_req.we) begin
			unique case (idx)
				IDX_CTL_A: s_next.rdat = s_reg.ctl_a;
				IDX_SYNC_STATUS: s_next.rdat = {4'h0, s_reg.busy_match != 2'h0,
					s_reg.busy_top != 2'h0, s_reg.busy_count != 2'h0,
					s_reg.busy_ctl != 2'h0};
				IDX_IRQ_EN: s_next.rdat = {6'h00, s_reg.irq_en};
				IDX_IRQ_FLAGS: s_next.rdat = {6'h00, s_reg.flags};
				IDX_WIDE_BUF: s_next.rdat = s_reg.wide_buf;
				IDX_DEBUG: s_next.rdat = {7'h00, s_reg.run_halted};
				IDX_CLK_SEL: s_next.rdat = {6'h00, s_reg.clk_src_sel};
				IDX_COUNT_L: begin
					// Low read latches high byte for a coherent pair
					s_next.rdat = s_reg.count[7:0];
					s_next.wide_buf = s_reg.count[15:8];
				end
				IDX_TOP_L: begin
					s_next.rdat = s_reg.top[7:0];
					s_next.wide_buf = s_reg.top[15:8];
				end
				IDX_MATCH_L: begin
					s_next.rdat = s_reg.match[7:0];
					s_next.wide_buf = s_reg.match[15:8];
				end
				IDX_COUNT_H, IDX_TOP_H, IDX_MATCH_H: s_next.rdat = s_reg.wide_buf;
				IDX_PRD_CTL: s_next.rdat = s_reg.prd_ctl;
				IDX_PRD_STATUS: s_next.rdat = {7'h00, s_reg.busy_prd != 2'h0};
				IDX_PRD_IRQ_EN: s_next.rdat = {7'h00, s_reg.prd_irq_en};
				IDX_PRD_FLAGS: s_next.rdat = {7'h00, s_reg.prd_flag};
				IDX_PRD_DEBUG: s_next.rdat = {7'h00, s_reg.prd_run_halted};
				default: s_next.rdat = 8'h00;
			endcase
		end
		if (wr) begin
			unique case (idx)
				IDX_CTL_A: begin
					s_next.ctl_a = wd & CTL_A_WMASK;
					s_next.busy_ctl = SYNC_TICKS;
				end
				IDX_IRQ_EN: s_next.irq_en = wd[1:0];
				IDX_IRQ_FLAGS: s_next.flags = s_reg.flags & ~wd[1:0];
				IDX_WIDE_BUF, IDX_COUNT_L, IDX_TOP_L, IDX_MATCH_L: s_next.wide_buf = wd;
				IDX_DEBUG: s_next.run_halted = wd[0];
				IDX_CLK_SEL: s_next.clk_src_sel = wd[1:0];
				IDX_COUNT_H: begin
					// High write commits the pair
					s_next.count_stage = {wd, s_reg.wide_buf};
					s_next.busy_count = SYNC_TICKS;
				end
				IDX_TOP_H: begin
					s_next.top = {wd, s_reg.wide_buf};
					s_next.busy_top = SYNC_TICKS;
				end
				IDX_MATCH_H: begin
					s_next.match = {wd, s_reg.wide_buf};
					s_next.busy_match = SYNC_TICKS;
				end
				IDX_PRD_CTL: begin
					s_next.prd_ctl = wd & PRD_CTL_WMASK;
					s_next.busy_prd = SYNC_TICKS;
				end
				IDX_PRD_IRQ_EN: s_next.prd_irq_en = wd[0];
				IDX_PRD_FLAGS: s_next.prd_flag = s_reg.prd_flag & ~wd[0];
				IDX_PRD_DEBUG: s_next.prd_run_halted = wd[0];
				default: s_next.prd_flag = s_next.prd_flag;
			endcase
		end

		// Staged values land after the slow-domain countdown
		if (lands(s_reg.busy_ctl, tick)) begin
			s_next.ctl_a_act = s_reg.ctl_a;
		end
		if (lands(s_reg.busy_top, tick)) begin
			s_next.top_act = s_reg.top;
		end
		if (lands(s_reg.busy_match, tick)) begin
			s_next.match_act = s_reg.match;
		end
		if (lands(s_reg.busy_prd, tick)) begin
			s_next.prd_ctl_act = s_reg.prd_ctl;
		end
		// A fresh bus write restarts a countdown rather than stepping it
		if (!(wr && idx == IDX_CTL_A)) begin
			s_next.busy_ctl = step(s_reg.busy_ctl, tick);
		end
		if (!(wr && idx == IDX_COUNT_H)) begin
			s_next.busy_count = step(s_reg.busy_count, tick);
		end
		if (!(wr && idx == IDX_TOP_H)) begin
			s_next.busy_top = step(s_reg.busy_top, tick);
		end
		if (!(wr && idx == IDX_MATCH_H)) begin
			s_next.busy_match = step(s_reg.busy_match, tick);
		end
		if (!(wr && idx == IDX_PRD_CTL)) begin
			s_next.busy_prd = step(s_reg.busy_prd, tick);
		end

		// Run conditions
		standby_stop = (sleep_mode == SLEEP_STANDBY || sleep_mode == SLEEP_POWER_DOWN)
			&& !s_reg.ctl_a_act[RUN_IN_STANDBY_BIT];
		run_c = s_reg.ctl_a_act[COUNTER_ENABLE_BIT] && !standby_stop
			&& !(debug_halt && !s_reg.run_halted);
		// Sleep mode is deliberately not looked at here
		run_p = s_reg.prd_ctl_act[PERIODIC_ENABLE_BIT]
			&& !(debug_halt && !s_reg.prd_run_halted);

		// Counter path
		s_next.evt = '0;
		set_flags = 2'b00;
		ctick = run_c && tick && low_ones(s_reg.presc, s_reg.ctl_a_act[6:PRESC_LSB]);
		if (!s_reg.ctl_a_act[COUNTER_ENABLE_BIT]) begin
			s_next.presc = 15'h0000;
		end else if (run_c && tick) begin
			s_next.presc = s_reg.presc + 15'h0001;
		end
		if (ctick) begin
			if (s_reg.count == s_reg.top_act) begin
				s_next.count = 16'h0000;
				s_next.evt.wrap_source = 1'b1;
				set_flags[WRAP_SRC_BIT] = 1'b1;
			end else begin
				s_next.count = s_reg.count + 16'h0001;
			end
			if (s_reg.count == s_reg.match_act) begin
				s_next.evt.compare_match_source = 1'b1;
				set_flags[MATCH_SRC_BIT] = 1'b1;
			end
		end
		// Software count value overrides a concurrent count step
		if (lands(s_reg.busy_count, tick)) begin
			s_next.count = s_reg.count_stage;
		end
		// Hardware set wins over a same-cycle clear
		s_next.flags = s_next.flags | set_flags;

		// Periodic timer path
		ptick = run_p && tick;
		if (!s_reg.prd_ctl_act[PERIODIC_ENABLE_BIT]) begin
			s_next.prd_count = 15'h0000;
		end else if (ptick) begin
			s_next.prd_count = s_reg.prd_count + 15'h0001;
		end
		for (int k = 0; k < PRD_EVT_N; k++) begin
			s_next.evt.periodic[k] = ptick
				&& low_ones(s_reg.prd_count, PRD_EVT_LOG2_MAX - 4'(k));
		end
		prd_code = s_reg.prd_ctl_act[6:PRD_FIELD_LSB];
		if (ptick && prd_code != 4'h0
			&& low_ones(s_reg.prd_count, prd_code + 4'h1)) begin
			s_next.prd_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.ctl_a <= CTL_A_RST;
			s_reg.ctl_a_act <= CTL_A_RST;
			s_reg.top <= TOP_RST;
			s_reg.top_act <= TOP_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Vector VEC_COUNTER shares both counter sources; VEC_PERIODIC is the timer
	assign irq_counter = |(s_reg.irq_en & s_reg.flags);
	assign irq_periodic = s_reg.prd_irq_en & s_reg.prd_flag;
	assign events = s_reg.evt;
	// One driver for the whole response word
	assign wb_rsp = '{ack: s_reg.ack, dat: {24'h000000, s_reg.rdat}};
endmodule // rcp_top

// File: verif/rcp_top_asserts.sv
// Checker for the bus, event and interrupt outputs of the slow counter block
`timescale 1ns/100ps
module rcp_top_asserts
	import rcp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire rcp_pkg::rcp_wb_req_t wb_req,
	input wire rcp_pkg::rcp_wb_rsp_t wb_rsp,
	input wire logic irq_counter,
	input wire logic irq_periodic,
	input wire rcp_pkg::rcp_evt_t events
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_ack_next;
		wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_once;
		wb_rsp.ack |=> !wb_rsp.ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_cause;
		$rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
	property p_dat_byte;
		wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0;
	endproperty
	a_dat_byte: assert property (p_dat_byte) else $error("read upper bits set");
	property p_wrap_pulse;
		events.wrap_source |=> !events.wrap_source;
	endproperty
	a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap not a pulse");
	property p_match_pulse;
		events.compare_match_source |=> !events.compare_match_source;
	endproperty
	a_match_pulse: assert property (p_match_pulse) else $error("match not a pulse");
	property p_prd_gap;
		events.periodic[7] |=> !events.periodic[7] [*8];
	endproperty
	a_prd_gap: assert property (p_prd_gap) else $error("periodic too close");
	property p_irqc_hold;
		$fell(irq_counter) |-> wb_rsp.ack;
	endproperty
	a_irqc_hold: assert property (p_irqc_hold) else $error("counter irq dropped");
	property p_irqp_hold;
		$fell(irq_periodic) |-> wb_rsp.ack;
	endproperty
	a_irqp_hold: assert property (p_irqp_hold) else $error("periodic irq dropped");
	c_ack: cover property (wb_rsp.ack);
	c_wrap: cover property (events.wrap_source);
	c_prd: cover property (events.periodic[7]);
	c_irq: cover property ($rose(irq_periodic));
endmodule // rcp_top_asserts

bind rcp_top rcp_top_asserts rcp_top_asserts_i (.clk_sys, .sys_rst, .wb_req, .wb_rsp,
	.irq_counter, .irq_periodic, .events);

// File: verif/rcp_evt_sink.sv
// Event sink model that times the wrap and fastest periodic events
`timescale 1ns/100ps
module rcp_evt_sink (
	input wire logic clk_sys,
	input wire rcp_pkg::rcp_evt_t events,
	output int wrap_gap,
	output int prd_gap,
	output int n_wrap,
	output int match_lead,
	output int n_prd
);
	import rcp_pkg::*;
	int tw = 0;
	int tp = 0;
	// Outputs by NBA so readers at the same edge see stable values
	always @(posedge clk_sys) begin
		tw++;
		tp++;
		// Cycles from the last wrap to this compare
		if (events.compare_match_source === 1'b1) begin
			match_lead <= tw;
		end
		if (events.wrap_source === 1'b1) begin
			wrap_gap <= tw;
			n_wrap <= n_wrap + 1;
			tw = 0;
		end
		if (events.periodic[7] === 1'b1) begin
			prd_gap <= tp;
			n_prd <= n_prd + 1;
			tp = 0;
		end
	end
endmodule // rcp_evt_sink

// File: verif/rcp_top_tb.sv
// Testbench for the slow counter and periodic timer block
`timescale 1ns/100ps
module rcp_top_tb;
	import rcp_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	rcp_wb_req_t wb_req = '0;
	rcp_wb_rsp_t wb_rsp;
	logic [7:0] sc = 8'h00;
	rcp_sleep_t sleep_mode = SLEEP_ACTIVE;
	logic debug_halt = 1'b0;
	logic irq_counter;
	logic irq_periodic;
	rcp_evt_t events;
	int wrap_gap, prd_gap, n_wrap, snap, match_lead, n_prd, snap_p;
	int failures = 0;
	int n_compared = 0;
	logic [7:0] q;
	// Clocks per slow tick for each source
	int tick[4] = '{4, 64, 8, 16};
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) sc <= sc + 8'h01;
	rcp_top rcp_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.internal_low_power_osc(sc[1]), .internal_low_power_osc_1k(sc[5]),
		.watch_crystal_osc(sc[2]), .external_slow_clock_pin(sc[3]), .sleep_mode(sleep_mode),
		.debug_halt(debug_halt), .irq_counter(irq_counter), .irq_periodic(irq_periodic),
		.events(events));
	rcp_evt_sink rcp_evt_sink_i (.clk_sys(clk_sys), .events(events), .wrap_gap(wrap_gap),
		.prd_gap(prd_gap), .n_wrap(n_wrap), .match_lead(match_lead), .n_prd(n_prd));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Classic single cycle; called right after a rising edge
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hf, dat: {24'h0, d}};
		// No fixed wait; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (wb_rsp.ack !== 1'b1);
		q = wb_rsp.dat[7:0];
		wb_req <= '0;
		@(posedge clk_sys);
	endtask
	task automatic rdc(input string name, input logic [5:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(name, {8'h0, exp}, {8'h0, q});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rdc("ctl_a", IDX_CTL_A, CTL_A_RST);
		rdc("top_l", IDX_TOP_L, 8'hff);
		rdc("top_h", IDX_TOP_H, 8'hff);
		xfer(1'b1, 6'h06, 8'h5a);
		rdc("unmapped", 6'h06, 8'h00);
		xfer(1'b1, IDX_SYNC_STATUS, 8'h0f);
		rdc("status", IDX_SYNC_STATUS, 8'h00);
		$display("test reset done");
		xfer(1'b1, IDX_CLK_SEL, 8'h00);
		xfer(1'b1, IDX_TOP_L, 8'h03);
		xfer(1'b1, IDX_TOP_H, 8'h00);
		xfer(1'b1, IDX_PRD_CTL, 8'h09);
		rdc("prd_busy", IDX_PRD_STATUS, 8'h01);
		xfer(1'b1, IDX_CTL_A, 8'h01);
		for (int s = 0; s < 4; s++) begin
			xfer(1'b1, IDX_CLK_SEL, 8'(s));
			idle(150 * tick[s]);
			chk("wrap_gap", 16'(4 * tick[s]), wrap_gap[15:0]);
			chk("prd_gap", 16'(64 * tick[s]), prd_gap[15:0]);
		end
		$display("test clock select done");
		xfer(1'b1, IDX_CLK_SEL, 8'h00);
		xfer(1'b1, IDX_CTL_A, 8'h11);
		idle(600);
		chk("presc_gap", 16'h0040, wrap_gap[15:0]);
		xfer(1'b1, IDX_MATCH_L, 8'h02);
		xfer(1'b1, IDX_MATCH_H, 8'h00);
		rdc("match_busy", IDX_SYNC_STATUS, 8'h08);
		idle(300);
		// Compare at count 2 comes three prescaled steps after the wrap
		chk("match_lead", 16'h0030, match_lead[15:0]);
		rdc("flags_off", IDX_IRQ_FLAGS, 8'h03);
		chk("irq_off", 16'h0000, {15'h0, irq_counter});
		xfer(1'b1, IDX_IRQ_EN, 8'h03);
		chk("irq_on", 16'h0001, {15'h0, irq_counter});
		xfer(1'b1, IDX_CTL_A, 8'h00);
		idle(50);
		xfer(1'b1, IDX_IRQ_FLAGS, 8'h01);
		rdc("flags_w1c", IDX_IRQ_FLAGS, 8'h02);
		chk("irq_hold", 16'h0001, {15'h0, irq_counter});
		xfer(1'b1, IDX_IRQ_FLAGS, 8'h02);
		chk("irq_clr", 16'h0000, {15'h0, irq_counter});
		xfer(1'b1, IDX_COUNT_L, 8'h34);
		xfer(1'b1, IDX_COUNT_H, 8'h12);
		idle(50);
		rdc("count_l", IDX_COUNT_L, 8'h34);
		rdc("count_h", IDX_COUNT_H, 8'h12);
		$display("test counter flags done");
		xfer(1'b1, IDX_PRD_CTL, 8'h29);
		xfer(1'b1, IDX_PRD_IRQ_EN, 8'h01);
		idle(100);
		chk("irq_prd", 16'h0001, {15'h0, irq_periodic});
		// Code 5 flag shares its 64-tick boundary with the fastest event
		do begin
			@(posedge clk_sys);
		end while (events.periodic[7] !== 1'b1);
		xfer(1'b1, IDX_PRD_FLAGS, 8'h01);
		idle(200);
		chk("prd_early", 16'h0000, {15'h0, irq_periodic});
		idle(100);
		chk("prd_due", 16'h0001, {15'h0, irq_periodic});
		xfer(1'b1, IDX_PRD_CTL, 8'h00);
		idle(50);
		rdc("prd_flag", IDX_PRD_FLAGS, 8'h01);
		xfer(1'b1, IDX_PRD_FLAGS, 8'h01);
		chk("prd_clr", 16'h0000, {15'h0, irq_periodic});
		$display("test periodic done");
		xfer(1'b1, IDX_COUNT_L, 8'h00);
		xfer(1'b1, IDX_COUNT_H, 8'h00);
		xfer(1'b1, IDX_CTL_A, 8'h01);
		xfer(1'b1, IDX_PRD_CTL, 8'h01);
		sleep_mode <= SLEEP_STANDBY;
		idle(50);
		snap = n_wrap;
		snap_p = n_prd;
		// Long enough for one fastest periodic event
		idle(300);
		chk("standby_stop", 16'(snap), n_wrap[15:0]);
		chk("standby_prd", 16'h0001, {15'h0, n_prd > snap_p});
		xfer(1'b1, IDX_CTL_A, 8'h81);
		idle(200);
		chk("standby_run", 16'h0010, wrap_gap[15:0]);
		xfer(1'b1, IDX_CTL_A, 8'h01);
		sleep_mode <= SLEEP_IDLE;
		debug_halt <= 1'b1;
		idle(50);
		snap = n_wrap;
		idle(200);
		chk("halt_stop", 16'(snap), n_wrap[15:0]);
		xfer(1'b1, IDX_DEBUG, 8'h01);
		snap = n_wrap;
		idle(200);
		chk("idle_run", 16'h0001, {15'h0, n_wrap > snap});
		$display("test sleep done");
		results();
	end
	// Tests take about 17000 cycles
	initial begin
		idle(40000);
		failures++;
		results();
	end
endmodule // rcp_top_tb
